// ===== design/hpc_device.sv
// Purpose: device end of the host port control pins
// Assumes: pins synchronous to i_clk_sys; strobes active low
// Notes:   data path is abstract: writes land in small registers
//          reads hand the register value to the core, no data pins are driven
//          the access timer stands in for the internal transfer behind each accepted data strobe
`timescale 1ns/100ps
module hpc_device (
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   input  wire logic              i_port_mode_strap,
   input  wire logic              i_io_line_a_out,
   input  wire logic              i_io_line_b_out,
   input  wire logic              i_io_line_a_dir,
   input  wire logic              i_io_line_b_dir,
   output logic                   o_parallel_io_line_a,
   output logic                   o_parallel_io_line_b,
   output logic                   o_mux_mode,
   output logic [7:0]             o_host_address_register,
   output logic [7:0]             o_host_control_register,
   output logic [7:0]             o_host_data_register,
   output logic                   o_read_done,
   output logic [7:0]             o_read_byte,
   hpc_if.device                  bus
);
   import hpc_pkg::*;

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   typedef struct packed {
      // pin function and shared pin drivers
      logic       in_rst;
      logic       mux;
      logic       a_o;
      logic       a_oe;
      logic       b_o;
      logic       b_oe;
      // shared pin samples for the core
      logic       io_a;
      logic       io_b;
      // host handshake
      logic       rdy;
      logic       rdy_oe;
      logic       strb;
      logic [3:0] busy;
      // port registers
      logic [7:0] addr;
      logic [7:0] ctrl;
      logic [7:0] data;
      // read return toward the core
      logic       rd_done;
      logic [7:0] rd_byte;
   } hpc_dev_st_t;

   hpc_dev_st_t st_q;
   hpc_dev_st_t st_d;
   logic        strobe_on;
   logic        selected;
   logic        ena;
   hpc_sel_t    sel;

   // -------------------------------------------------------------------
   // pin decode
   // -------------------------------------------------------------------
   // strobes are taken as synchronous pins; an asynchronous host needs a synchroniser in front
   // combined strobe: either strobe low starts the access
   assign strobe_on = !bus.data_strobe_first_n || !bus.data_strobe_second_n;
   assign selected  = !bus.port_chip_select_n;
   assign ena       = bus.port_enable_in;
   assign sel       = hpc_sel_t'({bus.register_select_bit1, bus.register_select_bit0});

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb begin
      // defaults: hold state, pulses drop, strobe history follows the pins
      st_d         = st_q;
      st_d.rd_done = 1'b0;
      st_d.strb    = strobe_on;
      st_d.in_rst  = 1'b0;
      if (st_q.in_rst) begin
         // strap caught on the first edge after release, then frozen
         // later edges keep the captured mode until the next reset
         st_d.mux = i_port_mode_strap;
      end
      // shared pins: inputs in strobe mode, driven from the core's line and direction inputs in io mode
      if (st_d.mux) begin
         st_d.a_oe = 1'b0;
         st_d.b_oe = 1'b0;
         st_d.a_o  = 1'b0;
         st_d.b_o  = 1'b0;
      end else begin
         st_d.a_oe = st_q.in_rst ? 1'b0 : i_io_line_a_dir;
         st_d.b_oe = st_q.in_rst ? 1'b0 : i_io_line_b_dir;
         st_d.a_o  = i_io_line_a_out;
         st_d.b_o  = i_io_line_b_out;
      end
      // sample the shared pins for the core; in strobe mode this is the address strobe and byte identify level
      st_d.io_a = bus.host_address_strobe_n;
      st_d.io_b = bus.host_byte_identify;
      // access timer runs down on its own, even while the port is disabled
      if (st_q.busy != HPC_CNT_RST) begin
         st_d.busy = st_q.busy - 4'h1;
      end
      if (ena && st_q.mux && !st_q.in_rst) begin
         // address strobe only means something in multiplexed mode
         // the level is taken, so a long strobe keeps following the bus
         if (!bus.host_address_strobe_n && selected) begin
            st_d.addr = bus.host_bus;
         end
         // start on the strobe's leading edge; a strobe that stays low counts once
         // a strobe while the timer runs is dropped: ready already asked the host to wait
         if (strobe_on && !st_q.strb && selected && st_q.busy == HPC_CNT_RST) begin
            st_d.busy = 4'(HPC_ACCESS_CYC);
            if (bus.read_write_select) begin
               // reads return the register as it stood before this edge
               st_d.rd_done = 1'b1;
               unique case (sel)
                  HPC_SEL_CTRL:     st_d.rd_byte = st_q.ctrl;
                  HPC_SEL_ADDR:     st_d.rd_byte = st_q.addr;
                  HPC_SEL_DATA_INC: st_d.rd_byte = st_q.data;
                  default:          st_d.rd_byte = st_q.data;
               endcase
            end else begin
               // writes take the byte on the bus at the strobe's first edge
               case (sel)
                  HPC_SEL_CTRL:     st_d.ctrl = bus.host_bus;
                  HPC_SEL_ADDR:     st_d.addr = bus.host_bus;
                  HPC_SEL_DATA_INC: st_d.data = bus.host_bus;
                  default:          st_d.data = bus.host_bus;
               endcase
            end
            // auto-increment after the second byte of the host cycle
            if (sel == HPC_SEL_DATA_INC && bus.host_byte_identify) begin
               st_d.addr = st_q.addr + HPC_ADDR_STEP;
            end
         end
      end
      // ready low while an access is still in flight
      st_d.rdy    = (st_d.busy == HPC_CNT_RST);
      st_d.rdy_oe = ena;
      // disabled port: all shared pin drivers off
      if (!ena) begin
         st_d.a_oe = 1'b0;
         st_d.b_oe = 1'b0;
      end
      // synchronous reset overrides all of the above; ready and shared pins float
      if (i_rst) begin
         st_d        = '0;
         st_d.in_rst = 1'b1;
         st_d.addr   = HPC_ADDR_RST;
         st_d.ctrl   = HPC_CTRL_RST;
         st_d.data   = HPC_DATA_RST;
      end
   end

   // -------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------
   // one register for all state keeps every output a flip-flop
   always_ff @(posedge i_clk_sys) begin
      st_q <= st_d;
   end

   // -------------------------------------------------------------------
   // pins toward the host
   // -------------------------------------------------------------------
   // control pin direction: host control inputs stay inputs, apart from the two shared pins in io mode
   // no output enable exists for select, chip select, direction or data strobes,
   // so those pins cannot be driven by this end in any mode
   assign bus.shared_ctrl_pin_a_o  = st_q.a_o;
   assign bus.shared_ctrl_pin_a_oe = st_q.a_oe;
   assign bus.shared_ctrl_pin_b_o  = st_q.b_o;
   assign bus.shared_ctrl_pin_b_oe = st_q.b_oe;
   assign bus.port_ready_out       = st_q.rdy;
   assign bus.port_ready_oe        = st_q.rdy_oe;

   // -------------------------------------------------------------------
   // values toward the core
   // -------------------------------------------------------------------
   // all straight from the state register
   assign o_parallel_io_line_a     = st_q.io_a;
   assign o_parallel_io_line_b     = st_q.io_b;
   assign o_mux_mode               = st_q.mux;
   assign o_host_address_register  = st_q.addr;
   assign o_host_control_register  = st_q.ctrl;
   assign o_host_data_register     = st_q.data;
   assign o_read_done              = st_q.rd_done;
   assign o_read_byte              = st_q.rd_byte;
endmodule : hpc_device

// ===== design/hpc_pkg.sv
// Purpose: shared constants and types for the host port control pins
// Assumes: one clock at 200 MHz, synchronous active-high reset
// Notes:   both ends import this package
package hpc_pkg;
   // -------------------------------------------------------------------
   // register select encodings
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      HPC_SEL_CTRL     = 2'h0,
      HPC_SEL_DATA_INC = 2'h1,
      HPC_SEL_ADDR     = 2'h2,
      HPC_SEL_DATA     = 2'h3
   } hpc_sel_t;

   // -------------------------------------------------------------------
   // timing and reset values
   // -------------------------------------------------------------------
   localparam real         HPC_CLK_NS       = 5.0;
   localparam real         HPC_ACCESS_NS    = 20.0;
   localparam int unsigned HPC_ACCESS_CYC   = ((HPC_ACCESS_NS / HPC_CLK_NS) < 1.0) ? 1 :
                                              int'($ceil(HPC_ACCESS_NS / HPC_CLK_NS));
   localparam logic [7:0]  HPC_ADDR_RST     = 8'h00;
   localparam logic [7:0]  HPC_CTRL_RST     = 8'h00;
   localparam logic [7:0]  HPC_DATA_RST     = 8'h00;
   localparam logic [3:0]  HPC_CNT_RST      = 4'h0;
   localparam logic [7:0]  HPC_ADDR_STEP    = 8'h01;
endpackage : hpc_pkg

// ===== design/hpc_if.sv
// Purpose: host bus wires between host and device ends
// Assumes: all signals synchronous to i_clk_sys
// Notes:   data bus modelled one way only, host to device; shared pins are three signals each
`timescale 1ns/100ps
interface hpc_if;
   logic       port_enable_in;
   logic       shared_ctrl_pin_a_o;
   logic       shared_ctrl_pin_a_oe;
   logic       shared_ctrl_pin_b_o;
   logic       shared_ctrl_pin_b_oe;
   logic       host_address_strobe_n;
   logic       host_byte_identify;
   logic       register_select_bit0;
   logic       register_select_bit1;
   logic       port_chip_select_n;
   logic       read_write_select;
   logic       data_strobe_first_n;
   logic       data_strobe_second_n;
   logic [7:0] host_bus;
   logic       port_ready_out;
   logic       port_ready_oe;

   modport device (
      input  port_enable_in, host_address_strobe_n, host_byte_identify,
             register_select_bit0, register_select_bit1, port_chip_select_n,
             read_write_select, data_strobe_first_n, data_strobe_second_n, host_bus,
      output shared_ctrl_pin_a_o, shared_ctrl_pin_a_oe, shared_ctrl_pin_b_o,
             shared_ctrl_pin_b_oe, port_ready_out, port_ready_oe
   );
   modport host (
      output port_enable_in, host_address_strobe_n, host_byte_identify,
             register_select_bit0, register_select_bit1, port_chip_select_n,
             read_write_select, data_strobe_first_n, data_strobe_second_n, host_bus,
      input  shared_ctrl_pin_a_o, shared_ctrl_pin_a_oe, shared_ctrl_pin_b_o,
             shared_ctrl_pin_b_oe, port_ready_out, port_ready_oe
   );
endinterface : hpc_if

// ===== design/hpc_host.sv
// Purpose: host end driving the multiplexed host port
// Assumes: device ready visible on the link; one request at a time
// Notes:   each request is two byte transfers, first then second
`timescale 1ns/100ps
module hpc_host (
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   input  wire logic              i_req,
   input  wire logic [1:0]        i_sel,
   input  wire logic              i_read,
   input  wire logic [7:0]        i_byte0,
   input  wire logic [7:0]        i_byte1,
   input  wire logic              i_enable,
   output logic                   o_busy,
   output logic                   o_done,
   hpc_if.host                    bus
);
   import hpc_pkg::*;

   typedef enum logic [2:0] {HPC_H_IDLE, HPC_H_WAIT, HPC_H_STRB, HPC_H_GAP} hpc_hstate_t;

   typedef struct packed {
      hpc_hstate_t fsm;
      logic        second;
      logic        cs_n;
      logic        ds_n;
      logic        as_n;
      logic        bil;
      logic        rw;
      logic [1:0]  sel;
      logic [7:0]  b0;
      logic [7:0]  b1;
      logic [7:0]  drv;
      logic        busy;
      logic        done;
      logic        ena;
   } hpc_host_st_t;

   hpc_host_st_t st_q;
   hpc_host_st_t st_d;

   // -------------------------------------------------------------------
   // sequencer: wait ready, strobe one byte, release, repeat
   // -------------------------------------------------------------------
   always_comb begin
      st_d      = st_q;
      st_d.done = 1'b0;
      st_d.ena  = i_enable;
      case (st_q.fsm)
         HPC_H_IDLE: begin
            if (i_req) begin
               st_d.fsm    = HPC_H_WAIT;
               st_d.sel    = i_sel;
               st_d.rw     = i_read;
               st_d.b0     = i_byte0;
               st_d.b1     = i_byte1;
               st_d.second = 1'b0;
               st_d.busy   = 1'b1;
            end
         end
         HPC_H_WAIT: begin
            // ready must be driven and high before a transfer
            if (bus.port_ready_oe && bus.port_ready_out) begin
               st_d.fsm  = HPC_H_STRB;
               st_d.cs_n = 1'b0;
               // address writes go out on the address strobe; the device latches them at once
               if (st_q.sel == HPC_SEL_ADDR && !st_q.rw) begin
                  st_d.as_n = 1'b0;
               end else begin
                  st_d.ds_n = 1'b0;
               end
               st_d.bil  = st_q.second;
               st_d.drv  = st_q.second ? st_q.b1 : st_q.b0;
            end
         end
         HPC_H_STRB: begin
            st_d.fsm  = HPC_H_GAP;
            st_d.ds_n = 1'b1;
            st_d.as_n = 1'b1;
            st_d.cs_n = 1'b1;
         end
         HPC_H_GAP: begin
            if (st_q.second) begin
               st_d.fsm  = HPC_H_IDLE;
               st_d.busy = 1'b0;
               st_d.done = 1'b1;
            end else begin
               st_d.fsm    = HPC_H_WAIT;
               st_d.second = 1'b1;
            end
         end
         default: st_d.fsm = HPC_H_IDLE;
      endcase
      if (i_rst) begin
         st_d      = '0;
         st_d.fsm  = HPC_H_IDLE;
         // enable is a pin level, not reset state: ready can drive on the first edge after release
         st_d.ena  = i_enable;
         st_d.as_n = 1'b1;
         st_d.cs_n = 1'b1;
         st_d.ds_n = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      st_q <= st_d;
   end

   // address strobe only used for address writes; idle high otherwise
   assign bus.port_enable_in        = st_q.ena;
   assign bus.host_address_strobe_n = st_q.as_n;
   assign bus.host_byte_identify    = st_q.bil;
   assign bus.register_select_bit0  = st_q.sel[0];
   assign bus.register_select_bit1  = st_q.sel[1];
   assign bus.port_chip_select_n    = st_q.cs_n;
   assign bus.read_write_select     = st_q.rw;
   assign bus.data_strobe_first_n   = st_q.ds_n;
   assign bus.data_strobe_second_n  = 1'b1;
   assign bus.host_bus              = st_q.drv;
   assign o_busy                    = st_q.busy;
   assign o_done                    = st_q.done;
endmodule : hpc_host

// ===== verif/hpc_link_props.sv
// Purpose: concurrent checks on the link between host and device ends
// Assumes: one clock, synchronous active-high reset
// Notes:   the access length of 4 cycles is written out as a plain count
`timescale 1ns/100ps
module hpc_link_props (
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   input  wire logic port_enable_in,
   input  wire logic shared_ctrl_pin_a_oe,
   input  wire logic shared_ctrl_pin_b_oe,
   input  wire logic host_byte_identify,
   input  wire logic port_chip_select_n,
   input  wire logic data_strobe_first_n,
   input  wire logic data_strobe_second_n,
   input  wire logic port_ready_out,
   input  wire logic port_ready_oe
);
   localparam int PAIR_MAX = 40;
   logic          strobe;

   // either data strobe low counts as a strobe
   assign strobe = !(data_strobe_first_n && data_strobe_second_n);

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // -------------------------------------------------------------------
   // device side
   // -------------------------------------------------------------------
   rst_float_a: assert property ($past(i_rst) |-> !port_ready_oe && !shared_ctrl_pin_a_oe)
      else $error("ready or shared pin driven during reset");
   ready_after_rst_a: assert property ($past(i_rst) && port_enable_in |=> port_ready_oe && port_ready_out)
      else $error("ready not driven high after reset");
   disable_float_a: assert property (!port_enable_in |=> !port_ready_oe && !shared_ctrl_pin_b_oe)
      else $error("output driven while port disabled");
   ready_fall_a: assert property ($rose(strobe) && !port_chip_select_n && port_enable_in
                                  && port_ready_out |=> !port_ready_out)
      else $error("ready did not fall after accepted strobe");
   ready_len_a: assert property ($fell(port_ready_out) && port_ready_oe
                                 |-> !port_ready_out [*4] ##1 port_ready_out)
      else $error("ready low time is not the access length");
   ready_cause_a: assert property ($fell(port_ready_out) && port_ready_oe
                                   |-> $past(strobe) && !$past(port_chip_select_n))
      else $error("ready fell without a selected strobe");
   // -------------------------------------------------------------------
   // host side
   // -------------------------------------------------------------------
   byte_pair_a: assert property ($rose(strobe) && !host_byte_identify
                                 |-> ##[1:PAIR_MAX] ($rose(strobe) && host_byte_identify))
      else $error("first byte not followed by second byte");
   host_wait_a: assert property ($rose(strobe) |-> port_ready_out ##1 !strobe)
      else $error("strobe without ready or longer than one cycle");
   cs_strobe_a: assert property (strobe |-> !port_chip_select_n)
      else $error("strobe without chip select");
endmodule : hpc_link_props

// ===== verif/host_port_control_pins_test.sv
// Purpose: self-checking bench for host and device ends of the host port
// Assumes: inputs driven at the falling edge; reset held 20 cycles
// Notes:   written bytes repeat in both halves so either byte may land
`timescale 1ns/100ps
module host_port_control_pins_test;
   import hpc_pkg::*;
   typedef struct packed {
      logic [1:0] sel;
      logic       rd;
      logic [7:0] val;
      logic [7:0] e_addr;
      logic [7:0] e_ctrl;
      logic [7:0] e_data;
      logic [7:0] e_rd;
   } hpc_row_t;
   logic i_clk_sys, i_rst, strap, a_out, b_out, a_dir, b_dir, mux_mode, rd_done;
   logic i_req, i_read, i_enable, busy, done;
   logic io_a, io_b;
   logic [1:0] i_sel;
   logic [7:0] b0, b1, addr_q, ctrl_q, data_q, rd_byte, rb;
   int failures, comparisons, k;
   // ordinary accesses, every select code at least once
   hpc_row_t rows [8] = '{
      '{HPC_SEL_ADDR,     1'b0, 8'h10, 8'h10, 8'h00, 8'h00, 8'h00},
      '{HPC_SEL_DATA_INC, 1'b0, 8'h5A, 8'h11, 8'h00, 8'h5A, 8'h00},
      '{HPC_SEL_DATA,     1'b0, 8'h3C, 8'h11, 8'h00, 8'h3C, 8'h00},
      '{HPC_SEL_CTRL,     1'b0, 8'h81, 8'h11, 8'h81, 8'h3C, 8'h00},
      '{HPC_SEL_CTRL,     1'b1, 8'h00, 8'h11, 8'h81, 8'h3C, 8'h81},
      '{HPC_SEL_ADDR,     1'b1, 8'h00, 8'h11, 8'h81, 8'h3C, 8'h11},
      '{HPC_SEL_DATA,     1'b1, 8'h00, 8'h11, 8'h81, 8'h3C, 8'h3C},
      '{HPC_SEL_DATA_INC, 1'b1, 8'h00, 8'h12, 8'h81, 8'h3C, 8'h3C}};

   hpc_if link ();
   hpc_device u_hpc_device (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_port_mode_strap(strap),
      .i_io_line_a_out(a_out), .i_io_line_b_out(b_out), .i_io_line_a_dir(a_dir), .i_io_line_b_dir(b_dir),
      .o_parallel_io_line_a(io_a), .o_parallel_io_line_b(io_b), .o_mux_mode(mux_mode),
      .o_host_address_register(addr_q), .o_host_control_register(ctrl_q), .o_host_data_register(data_q),
      .o_read_done(rd_done), .o_read_byte(rd_byte), .bus(link));
   hpc_host u_hpc_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(i_req), .i_sel(i_sel), .i_read(i_read),
      .i_byte0(b0), .i_byte1(b1), .i_enable(i_enable), .o_busy(busy), .o_done(done), .bus(link));
   hpc_link_props u_hpc_link_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .port_enable_in(link.port_enable_in),
      .shared_ctrl_pin_a_oe(link.shared_ctrl_pin_a_oe), .shared_ctrl_pin_b_oe(link.shared_ctrl_pin_b_oe),
      .host_byte_identify(link.host_byte_identify), .port_chip_select_n(link.port_chip_select_n),
      .data_strobe_first_n(link.data_strobe_first_n), .data_strobe_second_n(link.data_strobe_second_n),
      .port_ready_out(link.port_ready_out), .port_ready_oe(link.port_ready_oe));

   // 200 MHz clock
   always #2.5 i_clk_sys = ~i_clk_sys;

   task automatic end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // one host request; read byte kept from the last read pulse
   task automatic do_req(input logic [1:0] sel, input logic rd, input logic [7:0] b, output logic [7:0] got);
      int n;
      got = 8'h00;
      @(negedge i_clk_sys);
      i_req = 1'b1;
      i_sel = sel;
      i_read = rd;
      b0 = b;
      b1 = b;
      @(negedge i_clk_sys);
      i_req = 1'b0;
      for (n = 0; n < 200; n++) begin
         if (rd_done === 1'b1) got = rd_byte;
         if (done === 1'b1) break;
         @(negedge i_clk_sys);
      end
      if (n == 200) begin
         check("done wait", 8'h01, 8'h00);
         end_sim();
      end
   endtask : do_req

   task automatic wait_n(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask : wait_n

   initial begin
      i_clk_sys = 1'b0;
      i_rst = 1'b1;
      strap = 1'b1;
      {a_out, b_out, a_dir, b_dir} = 4'h0;
      {i_req, i_read, i_enable, i_sel, b0, b1} = 21'h040000;
      failures = 0;
      comparisons = 0;
      wait_n(20);
      check("ready oe in reset", 8'h00, link.port_ready_oe);
      check("addr in reset", HPC_ADDR_RST, addr_q);
      i_rst = 1'b0;
      wait_n(3);
      check("ready after reset", 8'h01, {link.port_ready_oe, link.port_ready_out} == 2'h3);
      check("mux mode", 8'h01, mux_mode);
      a_dir = 1'b1;
      b_dir = 1'b1;
      wait_n(3);
      check("strobe pins stay inputs", 8'h00, {link.shared_ctrl_pin_a_oe, link.shared_ctrl_pin_b_oe});
      a_dir = 1'b0;
      b_dir = 1'b0;
      for (k = 0; k < 8; k++) begin
         do_req(rows[k].sel, rows[k].rd, rows[k].val, rb);
         check("addr", rows[k].e_addr, addr_q);
         check("ctrl", rows[k].e_ctrl, ctrl_q);
         check("data", rows[k].e_data, data_q);
         if (rows[k].rd) check("read byte", rows[k].e_rd, rb);
         check("host busy", 8'h00, busy);
      end
      strap = 1'b0;
      wait_n(3);
      check("mode held", 8'h01, mux_mode);
      i_enable = 1'b0;
      wait_n(3);
      check("disabled ready oe", 8'h00, link.port_ready_oe);
      i_enable = 1'b1;
      wait_n(3);
      check("enabled ready oe", 8'h01, link.port_ready_oe);
      // reset lands in the middle of a write
      i_req = 1'b1;
      i_sel = HPC_SEL_DATA;
      i_read = 1'b0;
      b0 = 8'h77;
      b1 = 8'h77;
      wait_n(1);
      i_req = 1'b0;
      wait_n(2);
      i_rst = 1'b1;
      wait_n(2);
      check("ready oe mid reset", 8'h00, link.port_ready_oe);
      check("data mid reset", HPC_DATA_RST, data_q);
      i_rst = 1'b0;
      wait_n(3);
      check("io mode", 8'h00, mux_mode);
      check("io pins inputs", 8'h00, {link.shared_ctrl_pin_a_oe, link.shared_ctrl_pin_b_oe});
      check("io line a", 8'h01, io_a);
      check("io line b", 8'h00, io_b);
      a_dir = 1'b1;
      a_out = 1'b1;
      strap = 1'b1;
      wait_n(3);
      check("io a driven", 8'h03, {link.shared_ctrl_pin_a_oe, link.shared_ctrl_pin_a_o});
      check("io b input", 8'h00, link.shared_ctrl_pin_b_oe);
      check("io mode held", 8'h00, mux_mode);
      end_sim();
   end
endmodule : host_port_control_pins_test
